// ---- hdl/rss_ramp_switch_stall.sv ----
`default_nettype none
module rss_ramp_switch_stall
  import rss_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic [VEL_W-1:0]  actual_velocity_i,
  input  wire logic [POS_W-1:0]  actual_position_i,
  input  wire logic [VEL_W-1:0]  thr_low_i,
  input  wire logic [VEL_W-1:0]  thr_high_i,
  input  wire logic [CFG_W-1:0]  switch_stop_config_i,
  input  wire logic              ref_left_i,
  input  wire logic              ref_right_i,
  input  wire logic              stop_clear_i,
  input  wire logic              filt_en_i,
  input  wire logic              fullstep_i,
  input  wire logic [LOAD_W-1:0] raw_load_i,
  input  wire logic [STHR_W-1:0] stall_threshold_i,
  output logic                   above_low_o,
  output logic                   above_high_o,
  output logic                   left_active_o,
  output logic                   right_active_o,
  output logic                   stop_hard_o,
  output logic                   stop_soft_o,
  output logic                   stall_flag_o,
  output logic                   latch_event_o,
  output logic      [POS_W-1:0]  latched_position_o,
  output logic                   standstill_o,
  output logic      [LOAD_W-1:0] load_measurement_o
);
  // =====================================================================
  // state
  typedef struct packed {
    logic              l_prev;
    logic              r_prev;
    rss_stop_e         stop;
    logic              stall;
    logic              lev;
    logic [POS_W-1:0]  latch;
    logic              above_lo;
    logic              above_hi;
    logic              still;
  } rss_st_s;
  rss_st_s s_q, s_d;

  // magnitude with low bits dropped, used for both thresholds
  function automatic logic [THR_W-1:0] rss_coarse(input logic [VEL_W-1:0] v);
    logic [VEL_W-1:0] m;
    m = v[VEL_W-1] ? (~v + 32'h0000_0001) : v;
    return m[VEL_W-2:THR_DROP];
  endfunction

  logic [LOAD_W-1:0] load;
  logic              load_vld;

  rss_load_meas u_load (
    .clk_i              (clk_i),
    .sys_rst_i          (sys_rst_i),
    .filt_en_i          (filt_en_i),
    .fullstep_i         (fullstep_i),
    .raw_load_i         (raw_load_i),
    .stall_threshold_i  (stall_threshold_i),
    .load_measurement_o (load),
    .load_valid_o       (load_vld)
  );

  logic l_act, r_act, l_rise, r_rise, stop_ev, stall_ev;
  always_comb begin
    s_d = s_q;
    l_act  = ref_left_i ^ switch_stop_config_i[CFG_POL_L];
    r_act  = ref_right_i ^ switch_stop_config_i[CFG_POL_R];
    l_rise = l_act && !s_q.l_prev;
    r_rise = r_act && !s_q.r_prev;
    s_d.l_prev = l_act;
    s_d.r_prev = r_act;
    stall_ev = switch_stop_config_i[CFG_STALL_STOP] && load_vld && (load == '0);
    stop_ev = (l_act && switch_stop_config_i[CFG_STOP_L])
           || (r_act && switch_stop_config_i[CFG_STOP_R]) || stall_ev;
    if (stall_ev) begin
      s_d.stall = 1'b1;
    end else if (stop_clear_i) begin
      s_d.stall = 1'b0;
    end
    if (stop_ev) begin
      s_d.stop = switch_stop_config_i[CFG_SOFT] ? RSS_SOFT : RSS_HARD;
    end else if (stop_clear_i) begin
      s_d.stop = RSS_RUN;
    end
    s_d.lev = (l_rise && switch_stop_config_i[CFG_LATCH_L])
           || (r_rise && switch_stop_config_i[CFG_LATCH_R]);
    if (s_d.lev) begin
      s_d.latch = actual_position_i;
    end
    s_d.above_lo = rss_coarse(actual_velocity_i) >= thr_low_i[VEL_W-2:THR_DROP];
    s_d.above_hi = rss_coarse(actual_velocity_i) >= thr_high_i[VEL_W-2:THR_DROP];
    s_d.still = (actual_velocity_i == VEL_ZERO);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_q <= '{l_prev: 1'b0, r_prev: 1'b0, stop: RSS_RUN, stall: 1'b0, lev: 1'b0,
               latch: LATCH_RST, above_lo: 1'b0, above_hi: 1'b0, still: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // =====================================================================
  // outputs
  assign above_low_o        = s_q.above_lo;
  assign above_high_o       = s_q.above_hi;
  assign left_active_o      = s_q.l_prev;
  assign right_active_o     = s_q.r_prev;
  assign stop_hard_o        = (s_q.stop == RSS_HARD);
  assign stop_soft_o        = (s_q.stop == RSS_SOFT);
  assign stall_flag_o       = s_q.stall;
  assign latch_event_o      = s_q.lev;
  assign latched_position_o = s_q.latch;
  assign standstill_o       = s_q.still;
  assign load_measurement_o = load;
endmodule // rss_ramp_switch_stall
`default_nettype wire

// ---- include/rss_pkg.sv ----
// Notes on behaviour
// - velocity threshold compares ignore the lowest eight bits of each threshold
// - enabled left and right switch events stop the motion
// - hard stop forces velocity to zero at once, no ramp
// - soft stop ramps velocity down using the deceleration setting
// - enabled latching copies actual position into latched position on the event
// - each switch input has a programmable active polarity
// - on switch hit position latches and motor stops; host waits, selects hold
// - signed stall threshold, zero neutral, positive less and negative more sensitive
// - filter bit gives one load result per electrical period, else standard mode
// - load measurement is 10 bits, 0 to 1023, higher means less load
// - load measurement falls toward zero as load reaches maximum
// - stall stop enable stops the motor when load measurement reaches zero
// - unfiltered load measurement updates once per full step
// - filtered load value averages four consecutive measurements
// - standstill flag is set whenever actual velocity is zero
`default_nettype none
package rss_pkg;
  // =====================================================================
  // widths
  localparam int VEL_W       = 32;
  localparam int POS_W       = 32;
  localparam int THR_W       = 23;
  localparam int THR_DROP    = 8;
  localparam int LOAD_W      = 10;
  localparam int STHR_W      = 7;
  localparam int FILT_N      = 4;
  localparam int FILT_SHIFT  = 2;
  localparam int ACC_W       = LOAD_W + FILT_SHIFT;
  // =====================================================================
  // switch_stop_config field positions
  localparam int CFG_W          = 8;
  localparam int CFG_STOP_L     = 0;
  localparam int CFG_STOP_R     = 1;
  localparam int CFG_POL_L      = 2;
  localparam int CFG_POL_R      = 3;
  localparam int CFG_LATCH_L    = 4;
  localparam int CFG_LATCH_R    = 5;
  localparam int CFG_SOFT       = 6;
  localparam int CFG_STALL_STOP = 7;
  // =====================================================================
  // reset values
  localparam logic [POS_W-1:0]  LATCH_RST = 32'h0000_0000;
  localparam logic [LOAD_W-1:0] LOAD_RST  = 10'h3FF;
  localparam logic [VEL_W-1:0]  VEL_ZERO  = 32'h0000_0000;
  localparam logic [1:0]        FCNT_RST  = 2'h0;
  localparam logic [1:0]        FCNT_LAST = 2'h3;
  typedef enum logic [2:0] {
    RSS_RUN  = 3'b001,
    RSS_SOFT = 3'b010,
    RSS_HARD = 3'b100
  } rss_stop_e;
endpackage : rss_pkg
`default_nettype wire

// ---- hdl/rss_load_meas.sv ----
`default_nettype none
module rss_load_meas
  import rss_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              filt_en_i,
  input  wire logic              fullstep_i,
  input  wire logic [LOAD_W-1:0] raw_load_i,
  input  wire logic [STHR_W-1:0] stall_threshold_i,
  output logic      [LOAD_W-1:0] load_measurement_o,
  output logic                   load_valid_o
);
  typedef struct packed {
    logic [ACC_W-1:0]  acc;
    logic [1:0]        cnt;
    logic [LOAD_W-1:0] load;
    logic              vld;
  } rss_lm_s;
  rss_lm_s s_q, s_d;

  // threshold offsets raw reading; positive raises reading, clamp at ends
  function automatic logic [LOAD_W-1:0] rss_apply_thr(input logic [LOAD_W-1:0] r,
                                                      input logic [STHR_W-1:0] t);
    logic signed [LOAD_W+1:0] sum;
    sum = $signed({2'b00, r}) + $signed({{(LOAD_W+2-STHR_W){t[STHR_W-1]}}, t});
    if (sum < 0) return '0;
    if (sum > $signed({2'b00, LOAD_RST})) return LOAD_RST;
    return sum[LOAD_W-1:0];
  endfunction

  logic [LOAD_W-1:0] adj;
  logic [ACC_W-1:0]  acc_n;
  always_comb begin
    s_d   = s_q;
    adj   = rss_apply_thr(raw_load_i, stall_threshold_i);
    acc_n = s_q.acc + {{FILT_SHIFT{1'b0}}, adj};
    s_d.vld = 1'b0;
    if (fullstep_i) begin
      if (!filt_en_i) begin
        s_d.load = adj;
        s_d.vld  = 1'b1;
        s_d.cnt  = FCNT_RST;
        s_d.acc  = '0;
      end else if (s_q.cnt == FCNT_LAST) begin
        s_d.load = acc_n[ACC_W-1:FILT_SHIFT];
        s_d.vld  = 1'b1;
        s_d.cnt  = FCNT_RST;
        s_d.acc  = '0;
      end else begin
        s_d.acc = acc_n;
        s_d.cnt = s_q.cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_q <= '{acc: '0, cnt: FCNT_RST, load: LOAD_RST, vld: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign load_measurement_o = s_q.load;
  assign load_valid_o       = s_q.vld;
endmodule // rss_load_meas
`default_nettype wire

// ---- verif/rss_monitor.sv ----
`default_nettype none
module rss_monitor
  import rss_pkg::*;
(
  input wire logic              clk_i, sys_rst_i, stop_clear_i, fullstep_i, ref_left_i,
  input wire logic              above_low_o, left_active_o, stop_hard_o, stop_soft_o,
  input wire logic              stall_flag_o, latch_event_o, standstill_o,
  input wire logic [VEL_W-1:0]  actual_velocity_i, thr_low_i,
  input wire logic [POS_W-1:0]  actual_position_i, latched_position_o,
  input wire logic [CFG_W-1:0]  switch_stop_config_i,
  input wire logic [LOAD_W-1:0] load_measurement_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [VEL_W-1:0] v   = actual_velocity_i;
  wire logic [POS_W-1:0] pos = actual_position_i;
  wire logic [CFG_W-1:0] cfg = switch_stop_config_i;
  // magnitude so both directions share one range
  wire logic [VEL_W-1:0] mag = v[31] ? -v : v;
  wire logic             ge  = mag[30:8] >= thr_low_i[30:8];
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ==================================================================
  // checks
  stand_flag_a: assert property (standstill_o == ($past(v) == 32'h0))
    else $error("standstill wrong");
  low_thr_a: assert property (above_low_o == $past(ge))
    else $error("threshold wrong");
  left_pol_a: assert property (left_active_o == $past(ref_left_i ^ cfg[2]))
    else $error("polarity wrong");
  latch_pos_a: assert property (latch_event_o |-> latched_position_o == $past(pos))
    else $error("latched value wrong");
  latch_rise_a: assert property ($rose(left_active_o) && $past(cfg[4]) |-> latch_event_o)
    else $error("latch missed");
  latch_hold_a: assert property (!latch_event_o |-> $stable(latched_position_o))
    else $error("latch moved");
  sw_stop_a: assert property (left_active_o && $past(cfg[0]) |->
    stop_soft_o == $past(cfg[6]) && stop_hard_o != $past(cfg[6]))
    else $error("stop kind wrong");
  stop_clear_a: assert property ($fell(stop_hard_o | stop_soft_o) |-> $past(stop_clear_i))
    else $error("stop dropped");
  stall_zero_a: assert property ($rose(stall_flag_o) |-> $past(load_measurement_o) == 10'h0)
    else $error("stall without zero");
  load_hold_a: assert property (!$past(fullstep_i) |-> $stable(load_measurement_o))
    else $error("load moved");
  cover property (latch_event_o);
  cover property ($rose(stop_hard_o));
  cover property ($rose(stall_flag_o));
endmodule // rss_monitor
bind rss_ramp_switch_stall rss_monitor u_rss_monitor (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .stop_clear_i(stop_clear_i), .fullstep_i(fullstep_i),
  .ref_left_i(ref_left_i), .above_low_o(above_low_o), .left_active_o(left_active_o),
  .stop_hard_o(stop_hard_o), .stop_soft_o(stop_soft_o), .stall_flag_o(stall_flag_o),
  .latch_event_o(latch_event_o), .standstill_o(standstill_o), .thr_low_i(thr_low_i),
  .actual_velocity_i(actual_velocity_i), .actual_position_i(actual_position_i),
  .latched_position_o(latched_position_o), .switch_stop_config_i(switch_stop_config_i),
  .load_measurement_o(load_measurement_o)
);
`default_nettype wire

// ---- verif/rss_motor_model.sv ----
`default_nettype none
module rss_motor_model
  import rss_pkg::*;
#(
  parameter logic [POS_W-1:0] START    = 32'h0000_0400,
  parameter int               RIGHT_PT = 32'h4000_0000
) (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             pos_wr_i,
  input  wire logic [VEL_W-1:0] vel_i,
  input  wire logic [POS_W-1:0] pos_val_i,
  output var  logic [POS_W-1:0] pos_o,
  output wire logic             left_o,
  output wire logic             right_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==================================================================
  // motor and switches
  // position register rewrite
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) pos_o <= START;
    else if (pos_wr_i) pos_o <= pos_val_i;
    else pos_o <= pos_o + vel_i;
  end
  assign left_o  = $signed(pos_o) <= 0;
  assign right_o = $signed(pos_o) >= RIGHT_PT;
endmodule // rss_motor_model
`default_nettype wire

// ---- verif/tb_rss_ramp_switch_stall.sv ----
`default_nettype none
module tb_rss_ramp_switch_stall
  import rss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst = 1'h1, clr_r = 1'h0, fstep = 1'h0, filt = 1'h0, wr = 1'h0;
  logic [31:0] vel = 32'h0, wval = 32'h0, p;
  logic [7:0]  cfg = 8'h0;
  logic [9:0]  raw = 10'h0;
  logic [6:0]  sthr = 7'h0;
  wire logic   refl, refr, lo, hi, la, ra, sh, ss, stall, lev, stand;
  wire logic [31:0] pos, lat;
  wire logic [9:0]  load;
  int err_total = 0, num_checks = 0, i;
  rss_ramp_switch_stall u_rss_ramp_switch_stall (
    .clk_i(clk), .sys_rst_i(rst), .actual_velocity_i(vel), .actual_position_i(pos),
    .thr_low_i(32'h0000_10FF), .thr_high_i(32'h0010_0000), .switch_stop_config_i(cfg),
    .ref_left_i(refl), .ref_right_i(refr), .stop_clear_i(clr_r), .filt_en_i(filt),
    .fullstep_i(fstep), .raw_load_i(raw), .stall_threshold_i(sthr), .above_low_o(lo),
    .above_high_o(hi), .left_active_o(la), .right_active_o(ra), .stop_hard_o(sh),
    .stop_soft_o(ss), .stall_flag_o(stall), .latch_event_o(lev),
    .latched_position_o(lat), .standstill_o(stand), .load_measurement_o(load));
  rss_motor_model u_rss_motor_model (.clk_i(clk), .sys_rst_i(rst), .pos_wr_i(wr),
    .vel_i(vel), .pos_val_i(wval), .pos_o(pos), .left_o(refl), .right_o(refr));
  // ==================================================================
  // tasks
  // wide enough that position words plus flags are compared whole
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic setv(input logic [31:0] v);
    @(posedge clk); vel <= v; cyc(2);
  endtask
  // one fullstep pulse carrying a raw reading
  task automatic fs(input logic [9:0] r, input logic [6:0] t);
    @(posedge clk); raw <= r; sthr <= t; fstep <= 1'h1;
    @(posedge clk); fstep <= 1'h0; cyc(1);
  endtask
  task automatic clr;
    @(posedge clk); clr_r <= 1'h1;
    @(posedge clk); clr_r <= 1'h0; cyc(1);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial forever #4 clk = ~clk;
  // hang guard, far beyond the hundred and eighty or so cycles needed
  initial begin
    #100000; err_total++; final_report;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0; cyc(1);
    chk({stand, sh, ss, load}, {3'h4, LOAD_RST});
    setv(32'h0010_00FF); chk({lo, hi}, 2'h3);
    setv(32'h000F_FFFF); chk({lo, hi, stand}, 3'h4);
    setv(32'h0000_0FFF); chk({lo, hi}, 2'h0);
    setv(32'hFFFF_F000); chk({lo, hi}, 2'h2);
    $display("-- thresholds done");
    chk(la, 1'h0);
    @(posedge clk); cfg <= 8'h51; vel <= 32'hFFFF_0000; #1;
    for (i = 0; i < 1000 && lev !== 1'h1; i++) begin p = pos; cyc(1); end
    chk({lev, lat, ss, sh}, {1'h1, p, 2'h2});
    setv(32'h0); chk(stand, 1'h1);
    clr; chk(ss, 1'h1);
    @(posedge clk); wr <= 1'h1; wval <= pos - lat;
    @(posedge clk); wr <= 1'h0;
    setv(32'h0001_0000); cyc(6); setv(32'h0);
    chk({la, lat}, {1'h0, p});
    clr; chk(ss, 1'h0);
    $display("-- homing done");
    for (i = 0; i < 2; i++) begin
      @(posedge clk); cfg <= i ? 8'h0A : 8'h05; cyc(2);
      chk({la, ra, sh, lev}, i ? 4'h6 : 4'hA);
      @(posedge clk); cfg <= 8'h0; cyc(1);
      clr; chk(sh, 1'h0);
    end
    $display("-- polarity done");
    @(posedge clk); cfg <= 8'h80;
    fs(10'd500, 7'h0); chk(load, 10'd500);
    fs(10'd500, 7'd10); chk(load, 10'd510);
    fs(10'd30, 7'h58); chk(load, 10'h0);
    chk({stall, sh}, 2'h3);
    @(posedge clk); cfg <= 8'h0; filt <= 1'h1;
    fs(10'd100, 7'h0); fs(10'd200, 7'h0); fs(10'd300, 7'h0);
    chk(load, 10'h0);
    fs(10'd400, 7'h0); chk(load, 10'd250);
    clr; chk({stall, sh}, 2'h0);
    $display("-- load done");
    final_report;
  end
endmodule // tb_rss_ramp_switch_stall
`default_nettype wire
